/* File: verilog/fpms_pkg.sv */
package fpms_pkg;

	// System clock period, 20 MHz
	localparam int SYS_CLK_PERIOD_NS = 50;
	// Programmer reference clock, 1 MHz
	localparam int PROG_CLK_FREQ_KHZ = 1000;
	localparam int PROG_CLK_PERIOD_NS = 1000000 / PROG_CLK_FREQ_KHZ;
	// Reference clock counts as lost after this many missing periods
	localparam int REF_WATCH_PERIODS = 4;
	localparam int REF_TIMEOUT_CYC =
		(REF_WATCH_PERIODS * PROG_CLK_PERIOD_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
	localparam int REF_AGE_W = 8;
	localparam logic [REF_AGE_W-1:0] REF_TIMEOUT = REF_AGE_W'(REF_TIMEOUT_CYC);
	localparam logic [REF_AGE_W-1:0] REF_AGE_ZERO = 8'h00;
	localparam logic [REF_AGE_W-1:0] REF_AGE_STEP = 8'h01;

	// Serial byte framing
	localparam int BYTE_W = 8;
	localparam int BIT_CNT_W = 3;
	localparam logic [BIT_CNT_W-1:0] BIT_FIRST = 3'h0;
	localparam logic [BIT_CNT_W-1:0] BIT_LAST = 3'h7;
	localparam logic [BIT_CNT_W-1:0] BIT_STEP = 3'h1;
	localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;

	// Pin levels
	localparam logic STRAP_NORMAL = 1'h1;
	localparam logic TXD_IDLE = 1'h1;
	localparam logic SCLK_IDLE = 1'h1;

	typedef enum logic [1:0] {
		MODE_RESET = 2'b00,
		MODE_NORMAL = 2'b01,
		MODE_SERIAL = 2'b10
	} fpms_mode_t;

	typedef enum logic [1:0] {
		LK_IDLE = 2'b00,
		LK_XFER = 2'b01
	} fpms_link_state_t;

	typedef struct packed {
		logic valid;
		logic [BYTE_W-1:0] data;
	} fpms_byte_t;

	typedef struct packed {
		logic sclk_in;
		logic rxd;
	} fpms_link_in_t;

	typedef struct packed {
		logic sclk_out;
		logic sclk_oe;
		logic txd;
	} fpms_link_out_t;

endpackage

/* File: verilog/fpms_sync.sv */
`timescale 1ns/1ns
`default_nettype none
module fpms_sync
	import fpms_pkg::*;
#(
	parameter int W = 1
) (
	input wire logic clk, // Destination clock
	input wire logic [W-1:0] d, // Asynchronous level
	output logic [W-1:0] q // Synchronised level
);

	logic [W-1:0] meta_reg;
	logic [W-1:0] q_reg;

	// No reset: the strap must be sampled while reset is still held
	always_ff @(posedge clk) begin
		meta_reg <= d;
		q_reg <= meta_reg;
	end

	assign q = q_reg;

endmodule
`default_nettype wire

/* File: verilog/fpms_pulse_xing.sv */
`timescale 1ns/1ns
`default_nettype none
module fpms_pulse_xing
	import fpms_pkg::*;
(
	input wire logic clk, // Destination clock
	input wire logic rst, // Destination reset, synchronous
	input wire logic tgl_in, // Toggle from the source domain
	output logic pulse // One-cycle event in destination
);

	logic [2:0] sh_reg;
	logic [2:0] sh_next;

	always_comb begin
		sh_next = {sh_reg[1:0], tgl_in};
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			sh_reg <= 3'h0;
		end else begin
			sh_reg <= sh_next;
		end
	end

	// Edge taken only between the second and third stage
	assign pulse = sh_reg[1] ^ sh_reg[2];

endmodule
`default_nettype wire

/* File: verilog/fpms_top.sv */
`timescale 1ns/1ns
`default_nettype none
// Function
// - Select low at reset enters serial programming
// - Select high or open runs user code
// - Mode fixed from select sampled at reset
// - Serial link runs on programmer's 1 MHz clock
// - Serial clock pin works as input or output
// - Data received on input, sent on output
module fpms_top
	import fpms_pkg::*;
(
	input wire logic ref_clk, // System clock, 20 MHz
	input wire logic sys_rst, // Power-on or initial reset
	input wire logic prog_mode_select_n, // Programming select strap
	input wire logic prog_ref_clock, // Programmer reference clock
	input wire fpms_link_in_t link_in, // Serial clock and data pins
	output fpms_link_out_t link_out, // Serial clock drive and data out
	input wire logic sclk_master, // Device drives the serial clock
	input wire fpms_byte_t tx_byte, // Byte offered for sending
	output logic tx_ready, // Send slot free
	output fpms_byte_t rx_byte, // Received byte, valid one cycle
	output logic core_run, // Core may fetch from code flash
	output logic flash_prog_sel, // Flash owned by programming logic
	output logic prog_clk_ok // Reference clock seen recently, serial programming mode only
);

	////////////////////////////////////////////////////////////////////////
	// System domain: mode selection

	fpms_mode_t mode_reg, mode_next;
	logic strap_s;
	logic core_run_reg, core_run_next;
	logic prog_sel_reg, prog_sel_next;

	fpms_sync #(.W(1)) u_strap_sync (
		.clk(ref_clk),
		.d(prog_mode_select_n),
		.q(strap_s)
	);

	always_comb begin
		mode_next = mode_reg;
		case (mode_reg)
			MODE_RESET: begin
				if (strap_s == STRAP_NORMAL) begin
					mode_next = MODE_NORMAL;
				end else begin
					mode_next = MODE_SERIAL;
				end
			end
			MODE_NORMAL, MODE_SERIAL: begin
				mode_next = mode_reg;
			end
			default: begin
				mode_next = MODE_RESET;
			end
		endcase
		if (sys_rst) begin
			mode_next = MODE_RESET;
		end
		core_run_next = (mode_next == MODE_NORMAL);
		prog_sel_next = (mode_next == MODE_SERIAL);
	end

	always_ff @(posedge ref_clk) begin
		mode_reg <= mode_next;
		core_run_reg <= core_run_next;
		prog_sel_reg <= prog_sel_next;
	end

	////////////////////////////////////////////////////////////////////////
	// System domain: byte handshake and clock watch

	logic rx_pulse;
	logic ack_pulse;
	logic hb_pulse;
	logic tx_accept;
	logic [BYTE_W-1:0] tx_hold_reg, tx_hold_next;
	logic tx_req_tgl_reg, tx_req_tgl_next;
	logic tx_pend_s_reg, tx_pend_s_next;
	logic tx_ready_reg, tx_ready_next;
	fpms_byte_t rx_byte_reg, rx_byte_next;
	logic [REF_AGE_W-1:0] ref_age_reg, ref_age_next;
	logic clk_ok_reg, clk_ok_next;
	logic [BYTE_W-1:0] rx_buf_reg;
	logic rx_tgl_reg;
	logic tx_ack_tgl_reg;
	logic hb_tgl_reg;

	fpms_pulse_xing u_rx_xing (
		.clk(ref_clk),
		.rst(sys_rst),
		.tgl_in(rx_tgl_reg),
		.pulse(rx_pulse)
	);

	fpms_pulse_xing u_ack_xing (
		.clk(ref_clk),
		.rst(sys_rst),
		.tgl_in(tx_ack_tgl_reg),
		.pulse(ack_pulse)
	);

	fpms_pulse_xing u_hb_xing (
		.clk(ref_clk),
		.rst(sys_rst),
		.tgl_in(hb_tgl_reg),
		.pulse(hb_pulse)
	);

	assign tx_accept = tx_byte.valid && tx_ready_reg;

	always_comb begin
		tx_hold_next = tx_hold_reg;
		tx_req_tgl_next = tx_req_tgl_reg;
		tx_pend_s_next = tx_pend_s_reg;
		// Holding register stays put until the link domain acknowledges
		if (tx_accept) begin
			tx_hold_next = tx_byte.data;
			tx_req_tgl_next = ~tx_req_tgl_reg;
			tx_pend_s_next = 1'h1;
		end else if (ack_pulse) begin
			tx_pend_s_next = 1'h0;
		end
		tx_ready_next = prog_sel_next && !tx_pend_s_next;
		rx_byte_next.valid = rx_pulse && prog_sel_reg;
		rx_byte_next.data = rx_pulse ? rx_buf_reg : rx_byte_reg.data;
		if (hb_pulse) begin
			ref_age_next = REF_AGE_ZERO;
		end else if (ref_age_reg == REF_TIMEOUT) begin
			ref_age_next = ref_age_reg;
		end else begin
			ref_age_next = REF_AGE_W'(ref_age_reg + REF_AGE_STEP);
		end
		clk_ok_next = prog_sel_reg && (ref_age_next != REF_TIMEOUT);
		if (sys_rst) begin
			tx_req_tgl_next = 1'h0;
			tx_pend_s_next = 1'h0;
			tx_ready_next = 1'h0;
			rx_byte_next = '0;
			ref_age_next = REF_TIMEOUT;
			clk_ok_next = 1'h0;
		end
	end

	always_ff @(posedge ref_clk) begin
		tx_hold_reg <= tx_hold_next;
		tx_req_tgl_reg <= tx_req_tgl_next;
		tx_pend_s_reg <= tx_pend_s_next;
		tx_ready_reg <= tx_ready_next;
		rx_byte_reg <= rx_byte_next;
		ref_age_reg <= ref_age_next;
		clk_ok_reg <= clk_ok_next;
	end

	////////////////////////////////////////////////////////////////////////
	// Link domain, on the programmer clock

	logic [1:0] ctl_s;
	logic link_rst;
	logic master_s;
	fpms_link_in_t pins_s;
	logic tx_req_pulse;
	logic xfer;
	logic rise;
	logic fall;
	fpms_link_state_t lk_state_reg, lk_state_next;
	logic [BIT_CNT_W-1:0] bit_cnt_reg, bit_cnt_next;
	logic [BYTE_W-1:0] rx_shift_reg, rx_shift_next;
	logic [BYTE_W-1:0] rx_buf_next;
	logic rx_tgl_next;
	logic [BYTE_W-1:0] tx_shift_reg, tx_shift_next;
	logic tx_pend_reg, tx_pend_next;
	logic tx_ack_tgl_next;
	logic hb_tgl_next;
	logic sclk_d_reg, sclk_d_next;
	fpms_link_out_t pin_reg, pin_next;

	fpms_sync #(.W(2)) u_ctl_sync (
		.clk(prog_ref_clock),
		.d({prog_sel_reg, sclk_master}),
		.q(ctl_s)
	);

	fpms_sync #(.W(2)) u_pin_sync (
		.clk(prog_ref_clock),
		.d(link_in),
		.q(pins_s)
	);

	// Link held in reset outside serial programming mode
	assign link_rst = !ctl_s[1];
	assign master_s = ctl_s[0];

	fpms_pulse_xing u_req_xing (
		.clk(prog_ref_clock),
		.rst(link_rst),
		.tgl_in(tx_req_tgl_reg),
		.pulse(tx_req_pulse)
	);

	assign xfer = (lk_state_reg == LK_XFER);
	// Own edges as master, pin edges as slave
	assign rise = master_s ? (xfer && !pin_reg.sclk_out) : (pins_s.sclk_in && !sclk_d_reg);
	assign fall = master_s ? (xfer && pin_reg.sclk_out) : (!pins_s.sclk_in && sclk_d_reg);

	always_comb begin
		lk_state_next = lk_state_reg;
		bit_cnt_next = bit_cnt_reg;
		rx_shift_next = rx_shift_reg;
		rx_buf_next = rx_buf_reg;
		rx_tgl_next = rx_tgl_reg;
		tx_shift_next = tx_shift_reg;
		tx_pend_next = tx_pend_reg || tx_req_pulse;
		tx_ack_tgl_next = tx_ack_tgl_reg;
		// Heartbeat proves the programmer clock runs
		hb_tgl_next = ~hb_tgl_reg;
		sclk_d_next = pins_s.sclk_in;
		// Sample receive data on rising edge
		if (rise) begin
			rx_shift_next = {rx_shift_reg[BYTE_W-2:0], pins_s.rxd};
			bit_cnt_next = BIT_CNT_W'(bit_cnt_reg + BIT_STEP);
			if (bit_cnt_reg == BIT_LAST) begin
				rx_buf_next = rx_shift_next;
				rx_tgl_next = ~rx_tgl_reg;
				lk_state_next = LK_IDLE;
			end
		end
		// Shift send data on falling edge
		if (fall && xfer && bit_cnt_reg != BIT_FIRST) begin
			tx_shift_next = {tx_shift_reg[BYTE_W-2:0], TXD_IDLE};
		end
		// New byte loaded only at a byte boundary
		if (!xfer && tx_pend_reg && bit_cnt_reg == BIT_FIRST && !rise) begin
			tx_shift_next = tx_hold_reg;
			tx_pend_next = 1'h0;
			tx_ack_tgl_next = ~tx_ack_tgl_reg;
			lk_state_next = LK_XFER;
		end
		// Drive the clock pin only as master
		pin_next.sclk_oe = master_s;
		pin_next.sclk_out = (master_s && xfer) ? ~pin_reg.sclk_out : SCLK_IDLE;
		pin_next.txd = (lk_state_next == LK_XFER) ? tx_shift_next[BYTE_W-1] : TXD_IDLE;
		if (link_rst) begin
			lk_state_next = LK_IDLE;
			bit_cnt_next = BIT_FIRST;
			rx_shift_next = BYTE_ZERO;
			rx_buf_next = BYTE_ZERO;
			rx_tgl_next = 1'h0;
			tx_shift_next = BYTE_ZERO;
			tx_pend_next = 1'h0;
			tx_ack_tgl_next = 1'h0;
			hb_tgl_next = 1'h0;
			sclk_d_next = SCLK_IDLE;
			pin_next = '{sclk_out: SCLK_IDLE, sclk_oe: 1'h0, txd: TXD_IDLE};
		end
	end

	always_ff @(posedge prog_ref_clock) begin
		lk_state_reg <= lk_state_next;
		bit_cnt_reg <= bit_cnt_next;
		rx_shift_reg <= rx_shift_next;
		rx_buf_reg <= rx_buf_next;
		rx_tgl_reg <= rx_tgl_next;
		tx_shift_reg <= tx_shift_next;
		tx_pend_reg <= tx_pend_next;
		tx_ack_tgl_reg <= tx_ack_tgl_next;
		hb_tgl_reg <= hb_tgl_next;
		sclk_d_reg <= sclk_d_next;
		pin_reg <= pin_next;
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs

	assign link_out = pin_reg;
	assign tx_ready = tx_ready_reg;
	assign rx_byte = rx_byte_reg;
	assign core_run = core_run_reg;
	assign flash_prog_sel = prog_sel_reg;
	assign prog_clk_ok = clk_ok_reg;

	////////////////////////////////////////////////////////////////////////
	// Checks

	a_serial_entry: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		(mode_reg == MODE_RESET && strap_s == 1'h0) |=> (prog_sel_reg && !core_run_reg)
	) else $error("low select did not enter serial programming");

	a_normal_entry: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		(mode_reg == MODE_RESET && strap_s == STRAP_NORMAL) |=> (core_run_reg && !prog_sel_reg)
	) else $error("high select did not enter normal mode");

	a_mode_fixed: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		(mode_reg != MODE_RESET) ##1 !sys_rst |-> $stable(mode_reg)
	) else $error("mode changed without reset");

	a_core_held: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		prog_sel_reg |=> (prog_sel_reg && !core_run_reg) [*2]
	) else $error("core released during programming");

	a_clock_lost: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		(!hb_pulse && ref_age_reg == REF_TIMEOUT) |=> !prog_clk_ok
	) else $error("clock ok kept after timeout");

	a_sclk_dir: assert property (
		@(posedge prog_ref_clock) disable iff (link_rst)
		!master_s ##1 !master_s |-> !link_out.sclk_oe
	) else $error("serial clock driven while slave");

	a_rx_complete: assert property (
		@(posedge prog_ref_clock) disable iff (link_rst)
		(rise && bit_cnt_reg == BIT_LAST) |=> ($changed(rx_tgl_reg) && bit_cnt_reg == BIT_FIRST)
	) else $error("byte not completed after eight edges");

	a_txd_idle: assert property (
		@(posedge prog_ref_clock) disable iff (link_rst)
		(lk_state_reg == LK_IDLE) |-> link_out.txd == TXD_IDLE
	) else $error("send data not idle between bytes");

endmodule
`default_nettype wire

/* File: bench/fpms_prog_model.sv */
`timescale 1ns/1ns
`default_nettype none
module fpms_prog_model
	import fpms_pkg::*;
(
	input wire fpms_link_out_t link_out, // Device pin drive
	output var logic prog_ref_clock, // Programmer clock
	output wire fpms_link_in_t link_in // Resolved pin levels
);
	logic ref_run = 1'b1;
	logic sclk_drv = SCLK_IDLE;
	logic rxd_drv = 1'b1;
	logic [7:0] reply = 8'hff;
	int rises = 8;
	initial prog_ref_clock = 1'b0;
	////////////////////////////////////////////////////////////////
	// programmer clock, bench rate
	always begin
		#62 prog_ref_clock = ref_run & ~prog_ref_clock;
		#63 prog_ref_clock = ref_run & ~prog_ref_clock;
	end
	// shared clock pin, pull-up when released
	assign link_in = {link_out.sclk_oe ? link_out.sclk_out : sclk_drv, rxd_drv};
	////////////////////////////////////////////////////////////////
	task automatic set_reply(input logic [7:0] d);
		reply = d;
		rises = 0;
		rxd_drv = d[7];
	endtask
	always @(posedge link_in.sclk_in) begin
		if (link_out.sclk_oe === 1'b1)
			rises++;
	end
	// reply MSB first, change on falling
	// Device sees the data pin two link clocks late, so the next bit
	// goes out one falling edge ahead of the rising edge that takes it
	always @(negedge link_in.sclk_in) begin
		if (link_out.sclk_oe === 1'b1 && rises < 7)
			rxd_drv = reply[6 - rises];
	end
	// parallel programming is the writer's own; not modelled here
	task automatic slave_byte(input logic [7:0] d);
		for (int i = 7; i >= 0; i--) begin
			@(posedge prog_ref_clock);
			#2 sclk_drv = 1'b0;
			rxd_drv = d[i];
			repeat (4) @(posedge prog_ref_clock);
			#2 sclk_drv = 1'b1;
			repeat (3) @(posedge prog_ref_clock);
		end
		// Released line floats to its pull-up
		rxd_drv = 1'b1;
	endtask
endmodule
`default_nettype wire

/* File: bench/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import fpms_pkg::*;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic prog_mode_select_n = 1'b1;
	logic sclk_master = 1'b0;
	fpms_byte_t tx_byte = '0;
	logic prog_ref_clock;
	fpms_link_in_t link_in;
	fpms_link_out_t link_out;
	logic tx_ready;
	fpms_byte_t rx_byte;
	logic core_run;
	logic flash_prog_sel;
	logic prog_clk_ok;
	int miscompares = 0;
	int tests_run = 0;
	int seed = 77390;
	int cycles = 0;
	int nb = 0;
	logic [7:0] sh;
	logic txd_seen = 1'b1;
	logic [7:0] b;
	logic [7:0] r;
	logic [7:0] rx_q[$];
	logic [7:0] tx_q[$];

	fpms_top dut (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.prog_mode_select_n(prog_mode_select_n),
		.prog_ref_clock(prog_ref_clock),
		.link_in(link_in),
		.link_out(link_out),
		.sclk_master(sclk_master),
		.tx_byte(tx_byte),
		.tx_ready(tx_ready),
		.rx_byte(rx_byte),
		.core_run(core_run),
		.flash_prog_sel(flash_prog_sel),
		.prog_clk_ok(prog_clk_ok)
	);
	fpms_prog_model pm (
		.link_out(link_out),
		.prog_ref_clock(prog_ref_clock),
		.link_in(link_in)
	);

	always #25 ref_clk = ~ref_clk;
	////////////////////////////////////////////////////////////////
	task automatic final_report();
		if (miscompares == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic check(input logic ok, input string msg);
		tests_run++;
		if (ok !== 1'b1) begin
			miscompares++;
			$display("unexpected %0t %s", $time, msg);
		end
	endtask
	// Strap set while reset is asserted, held through its release
	task automatic do_reset(input logic strap);
		@(posedge ref_clk);
		#2 sys_rst = 1'b1;
		prog_mode_select_n = strap;
		repeat (5) @(posedge ref_clk);
		#2 sys_rst = 1'b0;
		repeat (4) @(posedge ref_clk);
		#2;
	endtask
	task automatic wait_ready();
		int n;
		n = 0;
		do begin
			@(posedge ref_clk);
			#2 n++;
		end while (tx_ready !== 1'b1 && n < 2000);
		check(tx_ready === 1'b1, "send slot");
	endtask
	task automatic send(input logic [7:0] d);
		wait_ready();
		tx_q.push_back(d);
		tx_byte = {1'b1, d};
		@(posedge ref_clk);
		#2 tx_byte.valid = 1'b0;
	endtask
	task automatic wait_idle();
		int n;
		n = 0;
		while ((rx_q.size() > 0 || tx_q.size() > 0) && n < 4000) begin
			@(posedge ref_clk);
			n++;
		end
		check(n < 4000, "transfer stuck");
	endtask
	////////////////////////////////////////////////////////////////
	always @(posedge ref_clk) begin
		if (rx_byte.valid === 1'b1) begin
			check(rx_q.size() > 0 && rx_byte.data === rx_q[0], "rx byte");
			if (rx_q.size() > 0)
				void'(rx_q.pop_front());
		end
	end
	// Send pin as it stood before the clock edge; the last bit is
	// replaced by idle in the same update as the final rising edge
	always @(negedge prog_ref_clock) begin
		txd_seen = link_out.txd;
	end
	always @(posedge link_in.sclk_in) begin
		if (flash_prog_sel === 1'b1) begin
			check(link_out.sclk_oe === sclk_master, "clock direction");
			sh = {sh[6:0], txd_seen};
			nb++;
			if (nb == 8) begin
				nb = 0;
				check(tx_q.size() > 0 && sh === tx_q[0], "tx byte");
				if (tx_q.size() > 0)
					void'(tx_q.pop_front());
			end
		end
	end
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			final_report();
		end
	end
	////////////////////////////////////////////////////////////////
	initial begin
		do_reset(1'b1);
		check(core_run === 1'b1 && flash_prog_sel === 1'b0, "normal mode");
		check(tx_ready === 1'b0 && link_out.txd === TXD_IDLE, "link idle");
		do_reset(1'b0);
		check(flash_prog_sel === 1'b1 && core_run === 1'b0, "serial mode");
		// Link reset must clear and a heartbeat cross back first
		repeat (20) @(posedge ref_clk);
		#2 check(prog_clk_ok === 1'b1, "ref clock seen");
		// Strap moved after sampling must not matter
		prog_mode_select_n = 1'b1;
		sclk_master = 1'b1;
		for (int i = 0; i < 6; i++) begin
			b = 8'($random(seed));
			r = 8'($random(seed));
			rx_q.push_back(r);
			pm.set_reply(r);
			send(b);
			wait_idle();
		end
		check(flash_prog_sel === 1'b1 && core_run === 1'b0, "mode held");
		sclk_master = 1'b0;
		repeat (10) @(posedge ref_clk);
		for (int i = 0; i < 4; i++) begin
			b = 8'($random(seed));
			r = 8'($random(seed));
			rx_q.push_back(r);
			send(b);
			wait_ready();
			pm.slave_byte(r);
			wait_idle();
		end
		check(core_run === 1'b0, "core idle");
		pm.ref_run = 1'b0;
		repeat (120) @(posedge ref_clk);
		#2 check(prog_clk_ok === 1'b0, "ref clock lost");
		final_report();
	end
endmodule
`default_nettype wire
